// ### rtl/ctx_cfg.svh
// ctx_cfg: offsets, field positions, limits and counts for the can transmit block.
// assumes inclusion by bare name from every file that needs it.
`ifndef CTX_CFG_SVH
`define CTX_CFG_SVH

`define CTX_NBUF 2'h3
`define CTX_BUF_BYTES 6'h0e
`define CTX_MEM_AW 6

// timing_config_one fields
`define CTX_PRESC_LSB 0
`define CTX_JUMP_LSB 6
// timing_config_two fields
`define CTX_PROP_LSB 0
`define CTX_PH1_LSB 3
`define CTX_TRIPLE_BIT 6
`define CTX_PH2_LSB 8

// error counter limits
`define CTX_TEC_WARN 9'h060
`define CTX_TEC_PASSIVE 9'h07f
`define CTX_TEC_BUSOFF 9'h0ff
`define CTX_TEC_MAX 10'h100

// mdiv count on which the instruction clock ticks, once every four mclk cycles
`define CTX_FCY_DIV 2'h3

// reset values
`define CTX_FREE_RST 3'h7

`endif

// ### rtl/ctx_pkg.sv
// ctx_pkg: types shared by the can transmit block.
// assumes nothing beyond the tool supporting packed structs.
package ctx_pkg;

  typedef enum logic [2:0]
  {
    ctx_idle = 3'h1,
    ctx_settle = 3'h2,
    ctx_active = 3'h4
  } ctx_state_e;

  typedef logic [1:0] ctx_prio_t;

  typedef struct packed
  {
    logic [5:0] prescale;
    logic [1:0] jump;
    logic [2:0] prop;
    logic [2:0] ph1;
    logic [2:0] ph2;
    logic triple;
  } ctx_timing_s;

  typedef struct packed
  {
    logic ok;
    logic arb_lost;
    logic err_ack;
    logic err_form;
    logic err_bit;
  } ctx_result_s;

endpackage : ctx_pkg

// ### rtl/ctx_buf_mem.sv
// ctx_buf_mem: byte store for all transmit buffers, registered read port.
// assumes one writer and one reader, both on mclk.
module ctx_buf_mem
#(
  parameter int DEPTH = 42,
  parameter int AW = 6
)
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge mclk)
  begin
    if (wr_en && (int'(wr_addr) < DEPTH))
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= 8'h00;
    else if (int'(rd_addr) < DEPTH)
      rd_data <= mem[rd_addr];
    else
      rd_data <= 8'h00;
  end

endmodule : ctx_buf_mem

// ### rtl/ctx_sched.sv
// ctx_sched: can transmit scheduler, error counter and bit timing generator.
// assumes a protocol engine giving one result per started attempt, and
// synchronous inputs; mclk runs at four times the instruction clock.
`include "ctx_cfg.svh"

////////////////////////////////////////////////////////////////////////
module ctx_sched
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic buf_wr_en,
  input wire logic [1:0] buf_wr_sel,
  input wire logic [3:0] buf_wr_addr,
  input wire logic [7:0] buf_wr_data,
  input wire ctx_pkg::ctx_prio_t [`CTX_NBUF-1:0] tx_priority_level,
  input wire logic [`CTX_NBUF-1:0] req_set,
  input wire logic [`CTX_NBUF-1:0] req_clear,
  input wire logic abort_all_pending,
  input wire logic [`CTX_NBUF-1:0] free_flag_clear,
  input wire logic error_flag_clear,
  input wire logic [`CTX_NBUF-1:0] tx_interrupt_enable,
  input wire logic [15:0] timing_config_one,
  input wire logic [15:0] timing_config_two,
  input wire logic module_clock_select,
  input wire logic bus_idle,
  input wire logic can_rx,
  input wire logic [3:0] eng_rd_addr,
  input wire ctx_pkg::ctx_result_s eng_result,
  output logic eng_start,
  output logic [1:0] eng_buf,
  output logic [7:0] eng_rd_data,
  output logic [`CTX_NBUF-1:0] tx_send_request,
  output logic [`CTX_NBUF-1:0] tx_aborted_flag,
  output logic [`CTX_NBUF-1:0] tx_arbitration_lost_flag,
  output logic [`CTX_NBUF-1:0] tx_attempt_error_flag,
  output logic [`CTX_NBUF-1:0] tx_buffer_free_flag,
  output logic general_error_flag,
  output logic tx_warning_flag,
  output logic tx_error_passive_flag,
  output logic bus_off_flag,
  output logic tx_irq,
  output logic [8:0] tx_error_count,
  output logic bit_start,
  output logic sample_strobe,
  output logic sample_value
);

  ctx_pkg::ctx_timing_s tcfg;
  ctx_pkg::ctx_state_e state;
  logic [`CTX_NBUF-1:0] abort_pend;
  logic [`CTX_NBUF-1:0] avail;
  logic [`CTX_NBUF-1:0] kill;
  logic [`CTX_NBUF-1:0] fly;
  logic [`CTX_NBUF-1:0] done;
  logic go;
  logic attempt_end;
  logic [1:0] err_sum;
  logic [9:0] tsum;
  logic [8:0] next_tec;
  logic [1:0] mdiv;
  logic mod_tick;
  logic [5:0] hcnt;
  logic hph;
  logic half_tick;
  logic tq_tick;
  logic rx_prev;
  logic fall;
  logic hsync;
  logic [4:0] q;
  logic [4:0] s_at;
  logic [4:0] lend;
  logic lock;
  logic [4:0] jw;
  logic [4:0] lenj;
  logic [4:0] shrink;
  logic [4:0] nom_s;
  logic [4:0] nom_l;
  logic [1:0] hs;
  logic [9:0] tq_gap;
  logic tq_seen;
  logic [6:0] tq_cfg;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] pick_best(input logic [`CTX_NBUF-1:0] req,
    input ctx_pkg::ctx_prio_t [`CTX_NBUF-1:0] pr);
    logic [1:0] b;
    logic found;
    b = 2'h0;
    found = 1'b0;
    for (int i = 0; i < `CTX_NBUF; i++)
    begin
      if (req[i] && (!found || pr[i] > pr[b]))
      begin
        b = 2'(i);
        found = 1'b1;
      end
    end
    return b;
  endfunction : pick_best

  function automatic logic [4:0] seg_len(input logic [2:0] f);
    return {2'h0, f} + 5'h01;
  endfunction : seg_len

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction : maj3

  function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
    return (a < b) ? a : b;
  endfunction : min5

  ////////////////////////////////////////////////////////////////////////
  // buffer store

  ctx_buf_mem #(
    .DEPTH(3 * 14),
    .AW(`CTX_MEM_AW)
  ) u_mem (
    .mclk(mclk),
    .nrst(nrst),
    .wr_en(buf_wr_en),
    .wr_addr(6'(buf_wr_sel) * `CTX_BUF_BYTES + 6'(buf_wr_addr)),
    .wr_data(buf_wr_data),
    .rd_addr(6'(eng_buf) * `CTX_BUF_BYTES + 6'(eng_rd_addr)),
    .rd_data(eng_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // scheduler

  always_comb
  begin
    tcfg.prescale = timing_config_one[`CTX_PRESC_LSB +: 6];
    tcfg.jump = timing_config_one[`CTX_JUMP_LSB +: 2];
    tcfg.prop = timing_config_two[`CTX_PROP_LSB +: 3];
    tcfg.ph1 = timing_config_two[`CTX_PH1_LSB +: 3];
    tcfg.ph2 = timing_config_two[`CTX_PH2_LSB +: 3];
    tcfg.triple = timing_config_two[`CTX_TRIPLE_BIT];
  end

  assign attempt_end = (state == ctx_pkg::ctx_active) && (|eng_result);
  assign kill = req_clear | {`CTX_NBUF{abort_all_pending}};
  assign avail = tx_send_request & ~kill;
  assign go = (|avail) && bus_idle && !bus_off_flag;

  always_comb
  begin
    fly = '0;
    done = '0;
    for (int i = 0; i < `CTX_NBUF; i++)
    begin
      fly[i] = (state == ctx_pkg::ctx_active) && (eng_buf == 2'(i));
      done[i] = attempt_end && (eng_buf == 2'(i));
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ctx_pkg::ctx_idle;
      eng_start <= 1'b0;
      eng_buf <= 2'h0;
    end
    else
    begin
      eng_start <= 1'b0;
      case (state)
        ctx_pkg::ctx_idle:
          if (go)
            state <= ctx_pkg::ctx_settle;
        ctx_pkg::ctx_settle:
          if (go)
          begin
            state <= ctx_pkg::ctx_active;
            eng_start <= 1'b1;
            eng_buf <= pick_best(avail, tx_priority_level);
          end
          else
            state <= ctx_pkg::ctx_idle;
        ctx_pkg::ctx_active:
          if (attempt_end)
            state <= ctx_pkg::ctx_idle;
        default:
          state <= ctx_pkg::ctx_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per buffer request and flags

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_send_request <= '0;
      tx_aborted_flag <= '0;
      tx_arbitration_lost_flag <= '0;
      tx_attempt_error_flag <= '0;
      tx_buffer_free_flag <= `CTX_FREE_RST;
      abort_pend <= '0;
    end
    else
    begin
      for (int i = 0; i < `CTX_NBUF; i++)
      begin
        if (req_set[i])
        begin
          tx_send_request[i] <= 1'b1;
          tx_aborted_flag[i] <= 1'b0;
          tx_arbitration_lost_flag[i] <= 1'b0;
          tx_attempt_error_flag[i] <= 1'b0;
          tx_buffer_free_flag[i] <= 1'b0;
          abort_pend[i] <= 1'b0;
        end
        // in flight abort waits for result
        else if (kill[i] && fly[i] && !done[i])
          abort_pend[i] <= 1'b1;
        else if (kill[i] && !fly[i] && tx_send_request[i])
        begin
          tx_send_request[i] <= 1'b0;
          tx_aborted_flag[i] <= 1'b1;
        end
        if (free_flag_clear[i])
          tx_buffer_free_flag[i] <= 1'b0;
        if (done[i])
        begin
          if (eng_result.ok)
          begin
            tx_send_request[i] <= 1'b0;
            tx_buffer_free_flag[i] <= 1'b1;
            abort_pend[i] <= 1'b0;
          end
          else
          begin
            if (eng_result.arb_lost)
              tx_arbitration_lost_flag[i] <= 1'b1;
            if (eng_result.err_ack || eng_result.err_form || eng_result.err_bit)
              tx_attempt_error_flag[i] <= 1'b1;
            if ((abort_pend[i] || kill[i]) && !req_set[i])
            begin
              tx_send_request[i] <= 1'b0;
              tx_aborted_flag[i] <= 1'b1;
              abort_pend[i] <= 1'b0;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error counter

  always_comb
  begin
    err_sum = 2'h0;
    if (attempt_end && !eng_result.ok)
      err_sum = 2'({1'b0, eng_result.err_ack} + {1'b0, eng_result.err_form}
        + {1'b0, eng_result.err_bit});
    tsum = {1'b0, tx_error_count} + {8'h00, err_sum};
    next_tec = (tsum > `CTX_TEC_MAX) ? 9'(`CTX_TEC_MAX) : tsum[8:0];
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_error_count <= 9'h000;
      tx_warning_flag <= 1'b0;
      tx_error_passive_flag <= 1'b0;
      bus_off_flag <= 1'b0;
      general_error_flag <= 1'b0;
    end
    else
    begin
      tx_error_count <= next_tec;
      tx_warning_flag <= next_tec > `CTX_TEC_WARN;
      tx_error_passive_flag <= next_tec > `CTX_TEC_PASSIVE;
      bus_off_flag <= next_tec > `CTX_TEC_BUSOFF;
      if ((next_tec > `CTX_TEC_WARN) && !(tx_error_count > `CTX_TEC_WARN))
        general_error_flag <= 1'b1;
      else if (error_flag_clear)
        general_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      tx_irq <= 1'b0;
    else
      tx_irq <= (|(tx_buffer_free_flag & tx_interrupt_enable)) || general_error_flag;
  end

  ////////////////////////////////////////////////////////////////////////
  // quantum generation

  assign mod_tick = !module_clock_select || (mdiv == `CTX_FCY_DIV);
  // half quantum every prescale plus one ticks
  assign half_tick = mod_tick && (hcnt >= tcfg.prescale) && !hsync;
  assign tq_tick = half_tick && hph;
  assign fall = rx_prev && !can_rx;
  assign hsync = fall && bus_idle;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mdiv <= 2'h0;
      hcnt <= 6'h00;
      hph <= 1'b0;
      rx_prev <= 1'b1;
    end
    else
    begin
      mdiv <= mdiv + 2'h1;
      rx_prev <= can_rx;
      if (hsync)
      begin
        hcnt <= 6'h00;
        hph <= 1'b0;
      end
      else if (mod_tick)
      begin
        // a lowered prescale ends the half quantum at once, no wrap
        if (hcnt >= tcfg.prescale)
        begin
          hcnt <= 6'h00;
          hph <= !hph;
        end
        else
          hcnt <= hcnt + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit segments and synchronisation

  always_comb
  begin
    nom_s = 5'h01 + seg_len(tcfg.prop) + seg_len(tcfg.ph1);
    nom_l = nom_s + seg_len(tcfg.ph2);
    jw = {3'h0, tcfg.jump} + 5'h01;
    lenj = min5(q, jw);
    shrink = min5(lend - q, jw);
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= 5'h00;
      s_at <= 5'h00;
      lend <= 5'h00;
      lock <= 1'b0;
      bit_start <= 1'b0;
    end
    else
    begin
      bit_start <= 1'b0;
      // restart in sync segment, no resync
      if (hsync)
      begin
        q <= 5'h00;
        s_at <= nom_s;
        lend <= nom_l;
        lock <= 1'b1;
        bit_start <= 1'b1;
      end
      else
      begin
        if (fall && !lock && (q != 5'h00))
        begin
          lock <= 1'b1;
          if (q < s_at)
          begin
            s_at <= s_at + lenj;
            lend <= lend + lenj;
          end
          else
            lend <= lend - shrink;
        end
        if (tq_tick)
        begin
          if ((q + 5'h01) >= lend)
          begin
            q <= 5'h00;
            s_at <= nom_s;
            lend <= nom_l;
            lock <= 1'b0;
            bit_start <= 1'b1;
          end
          else
            q <= q + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sampling

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      hs <= 2'h3;
      sample_strobe <= 1'b0;
      sample_value <= 1'b1;
    end
    else
    begin
      sample_strobe <= 1'b0;
      if (half_tick)
        hs <= {hs[0], can_rx};
      // end of phase one, optional majority
      if (tq_tick && ((q + 5'h01) == s_at))
      begin
        sample_strobe <= 1'b1;
        sample_value <= tcfg.triple ? maj3(hs[1], hs[0], can_rx) : can_rx;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  // config change between ticks voids the next period check
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tq_gap <= 10'h000;
      tq_seen <= 1'b0;
      tq_cfg <= 7'h00;
    end
    else
    begin
      tq_cfg <= {module_clock_select, tcfg.prescale};
      if (hsync || tq_tick)
      begin
        tq_gap <= 10'h000;
        tq_seen <= tq_tick;
      end
      else
      begin
        tq_gap <= tq_gap + 10'h001;
        if (tq_cfg != {module_clock_select, tcfg.prescale})
          tq_seen <= 1'b0;
      end
    end
  end

  AST_REQ_CLEARS: assert property (@(posedge mclk) disable iff (!nrst)
    req_set[0] && !fly[0] |=> tx_send_request[0] && !tx_aborted_flag[0]
      && !tx_arbitration_lost_flag[0] && !tx_attempt_error_flag[0])
    else $error("request set did not enqueue cleanly");

  AST_START: assert property (@(posedge mclk) disable iff (!nrst)
    (state == ctx_pkg::ctx_settle) && go |=> eng_start && tx_send_request[eng_buf])
    else $error("settled start missing");

  AST_OK: assert property (@(posedge mclk) disable iff (!nrst)
    attempt_end && eng_result.ok |=> !tx_send_request[$past(eng_buf)]
      && tx_buffer_free_flag[$past(eng_buf)])
    else $error("success did not free buffer");

  AST_ARB: assert property (@(posedge mclk) disable iff (!nrst)
    attempt_end && !eng_result.ok && eng_result.arb_lost
      |=> tx_arbitration_lost_flag[$past(eng_buf)] && !tx_buffer_free_flag[$past(eng_buf)])
    else $error("arbitration loss mishandled");

  AST_ABORT: assert property (@(posedge mclk) disable iff (!nrst)
    kill[1] && !fly[1] && tx_send_request[1] && !req_set[1]
      |=> !tx_send_request[1] && tx_aborted_flag[1])
    else $error("abort not processed");

  AST_TEC_INC: assert property (@(posedge mclk) disable iff (!nrst)
    attempt_end && !eng_result.ok && eng_result.err_bit && !eng_result.err_ack
      && !eng_result.err_form && (tx_error_count < 9'h100)
      |=> tx_error_count == $past(tx_error_count) + 9'h001)
    else $error("error count not incremented");

  AST_WARN: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(tx_warning_flag) |-> general_error_flag ##1 tx_irq)
    else $error("warning without general error interrupt");

  AST_PASSIVE: assert property (@(posedge mclk) disable iff (!nrst)
    tx_error_passive_flag == (tx_error_count > 9'h07f))
    else $error("error passive flag wrong");

  AST_BUSOFF: assert property (@(posedge mclk) disable iff (!nrst)
    (tx_error_count > 9'h0ff) |-> bus_off_flag ##1 !eng_start)
    else $error("bus off not entered");

  AST_TQ: assert property (@(posedge mclk) disable iff (!nrst)
    tq_tick && tq_seen && $stable(tcfg.prescale) && $stable(module_clock_select)
      |-> tq_gap == 10'((int'(tcfg.prescale) + 1) * 2 * (module_clock_select ? 4 : 1) - 1))
    else $error("quantum period wrong");

  AST_SAMPLE: assert property (@(posedge mclk) disable iff (!nrst)
    sample_strobe |-> sample_value == ($past(tcfg.triple)
      ? maj3($past(hs[1]), $past(hs[0]), $past(can_rx)) : $past(can_rx)))
    else $error("sample value wrong");

endmodule : ctx_sched

// ### test/ctx_eng_model.sv
// ctx_eng_model: protocol engine stand-in, one result per started attempt.
// assumes the bench sets result kind and lag before each start.
module ctx_eng_model
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic eng_start,
  input wire ctx_pkg::ctx_result_s cmd,
  input wire logic [3:0] lag,
  output ctx_pkg::ctx_result_s eng_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  //////////////////////////////////////////////////////////////////////
  // commanded outcome
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt <= 5'h00;
      eng_result <= '0;
    end
    else
    begin
      eng_result <= '0;
      if (eng_start)
        cnt <= {1'b0, lag} + 5'h01;
      else if (cnt != 5'h00)
      begin
        cnt <= cnt - 5'h01;
        if (cnt == 5'h01)
          eng_result <= cmd;
      end
    end
  end
endmodule : ctx_eng_model

// ### test/can_tx_scheduler_bit_timing_test.sv
// can_tx_scheduler_bit_timing_test: self-checking bench for ctx_sched.
// assumes ctx_eng_model answers attempts; can_rx idles recessive.
module can_tx_scheduler_bit_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, nrst, wr_en, ab_all, err_clr, idle, can_rx, csel, st, gerr, warn, pas, boff;
  logic irq, bst, sst, sval;
  logic [1:0] wsel, ebuf;
  logic [3:0] wad, rad, lag;
  logic [7:0] wd, rd;
  logic [2:0] rset, rclr, fclr, ien, req, abt, arb, aer, free, pend;
  logic [15:0] cfg1, cfg2;
  logic [8:0] cnt;
  ctx_pkg::ctx_prio_t [2:0] pri;
  ctx_pkg::ctx_result_s res, cmd;
  logic [7:0] mem [3];
  int err_count, checks, r, k, n, m, e, per, so, ps, pr, p1, p2;
  ctx_sched u_dut (.mclk(mclk), .nrst(nrst), .buf_wr_en(wr_en), .buf_wr_sel(wsel),
    .buf_wr_addr(wad), .buf_wr_data(wd), .tx_priority_level(pri), .req_set(rset),
    .req_clear(rclr), .abort_all_pending(ab_all), .free_flag_clear(fclr),
    .error_flag_clear(err_clr), .tx_interrupt_enable(ien), .timing_config_one(cfg1),
    .timing_config_two(cfg2), .module_clock_select(csel), .bus_idle(idle), .can_rx(can_rx),
    .eng_rd_addr(rad), .eng_result(res), .eng_start(st), .eng_buf(ebuf), .eng_rd_data(rd),
    .tx_send_request(req), .tx_aborted_flag(abt), .tx_arbitration_lost_flag(arb),
    .tx_attempt_error_flag(aer), .tx_buffer_free_flag(free), .general_error_flag(gerr),
    .tx_warning_flag(warn), .tx_error_passive_flag(pas), .bus_off_flag(boff), .tx_irq(irq),
    .tx_error_count(cnt), .bit_start(bst), .sample_strobe(sst), .sample_value(sval));
  ctx_eng_model u_eng (.mclk(mclk), .nrst(nrst), .eng_start(st), .cmd(cmd), .lag(lag),
    .eng_result(res));
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int c);
    repeat (c) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic pulse(input logic [2:0] s, input logic [2:0] c, input logic a);
    @(posedge mclk);
    rset <= s;
    rclr <= c;
    ab_all <= a;
    @(posedge mclk);
    rset <= 3'h0;
    rclr <= 3'h0;
    ab_all <= 1'b0;
    #1;
  endtask : pulse
  task automatic wait_start(input logic want);
    int i;
    for (i = 0; i < 40 && st !== 1'b1; i++)
      cyc(1);
    chk("start", 16'(st === 1'b1), 16'(want));
  endtask : wait_start
  task automatic wait_res();
    int i;
    for (i = 0; i < 40 && res === '0; i++)
      cyc(1);
    cyc(1);
  endtask : wait_res
  function automatic logic [1:0] best(input logic [2:0] p, input ctx_pkg::ctx_prio_t [2:0] v);
    logic [1:0] b;
    b = 2'h3;
    for (int i = 0; i < 3; i++)
      if (p[i] && (b == 2'h3 || v[i] > v[b]))
        b = 2'(i);
    return b;
  endfunction : best
  initial
  begin
    #(5ns * 80000);
    err_count++;
    give_verdict();
  end
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, wr_en, ab_all, err_clr, csel, wsel, wad, wd, rset, rclr, fclr, ien} = '0;
    {pri, cfg1, cfg2, cmd} = '0;
    {idle, can_rx, rad, lag} = {2'h3, 4'hd, 4'h1};
    void'($urandom(32'h9e0bbbb4));
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    cyc(1);
    chk("free", 16'(free), 16'h7);
    ien <= 3'h7;
    cyc(2);
    chk("irq", 16'(irq), 16'h1);
    for (k = 0; k < 3; k++)
    begin
      @(posedge mclk);
      mem[k] = 8'($urandom);
      {wr_en, wsel, wad, wd} <= {1'b1, 2'(k), 4'hd, mem[k]};
    end
    @(posedge mclk);
    {wr_en, fclr} <= {1'b0, 3'h7};
    @(posedge mclk);
    fclr <= 3'h0;
    cmd <= 5'h10;
    for (r = 0; r < 8; r++)
    begin
      @(posedge mclk);
      pri <= (r < 2) ? {3{2'(r * 3)}} : 6'($urandom);
      pulse(3'h7, 3'h0, 1'b0);
      pend = 3'h7;
      for (k = 0; k < 3; k++)
      begin
        wait_start(1'b1);
        chk("buf", 16'(ebuf), 16'(best(pend, pri)));
        wait_res();
        pend[ebuf] = 1'b0;
        chk("data", 16'(rd), 16'(mem[ebuf]));
        chk("req", 16'(req), 16'(pend));
        chk("free", 16'(free[ebuf]), 16'h1);
      end
      cyc(1);
      chk("irq", 16'(irq), 16'h1);
      pulse(3'h0, 3'h0, 1'b0);
      fclr <= 3'h7;
      @(posedge mclk);
      fclr <= 3'h0;
      cyc(2);
      chk("irq", 16'(irq), 16'h0);
    end
    {cmd, lag} <= {5'h08, 4'h3};
    pulse(3'h1, 3'h0, 1'b0);
    wait_start(1'b1);
    idle <= 1'b0;
    wait_res();
    chk("req arb", 16'({req, arb}), 16'h09);
    cyc(1);
    chk("irq", 16'(irq), 16'h0);
    pulse(3'h0, 3'h1, 1'b0);
    chk("req abt free", 16'({req, abt, free}), 16'h008);
    pulse(3'h3, 3'h0, 1'b0);
    chk("req abt arb", 16'({req, abt, arb}), 16'h0c0);
    pulse(3'h0, 3'h0, 1'b1);
    chk("req abt", 16'({req, abt}), 16'h03);
    for (r = 0; r < 6; r++)
    begin
      {ps, pr, p1, p2} = {$urandom_range(3), $urandom_range(7), $urandom_range(7),
        $urandom_range(7)};
      // propagation plus phase one covers phase two
      p2 = (p2 > pr + p1 + 1) ? pr + p1 + 1 : p2;
      p1 = (pr + p1 + p2 < 4) ? 4 - pr - p2 : p1;
      @(posedge mclk);
      csel <= 1'($urandom);
      cfg1 <= {8'h00, 2'($urandom), 6'(ps)};
      cfg2 <= {5'h00, 3'(p2), 1'b0, 1'($urandom), 3'(p1), 3'(pr)};
      {k, n, m, so} = '0;
      while (k < 3 && n < 8000)
      begin
        cyc(1);
        n++;
        if (sst === 1'b1 && k == 2)
          so = n - m;
        if (bst === 1'b1)
          k++;
        if (bst === 1'b1 && k == 2)
          m = n;
      end
      per = 2 * (ps + 1) * (csel ? 4 : 1);
      chk("period", 16'(n - m), 16'(per * (4 + pr + p1 + p2)));
      chk("sample", 16'(so), 16'(per * (3 + pr + p1)));
      chk("value", 16'(sval), 16'h1);
    end
    @(posedge mclk);
    {idle, can_rx} <= 2'h2;
    cyc(1);
    chk("hard sync", 16'(bst), 16'h1);
    {idle, can_rx, cmd, lag} <= {2'h3, 5'h01, 4'h1};
    e = 0;
    pulse(3'h1, 3'h0, 1'b0);
    while (e < 256)
    begin
      wait_start(1'b1);
      wait_res();
      e = (e + $countones(cmd[2:0]) > 256) ? 256 : e + $countones(cmd[2:0]);
      chk("count", 16'(cnt), 16'(e));
      chk("levels", 16'({warn, pas, boff}), {13'h0, e > 96, e > 127, e > 255});
      chk("pending", 16'({req[0], aer[0]}), 16'h3);
      if (e > 96)
        chk("gerr", 16'(gerr), 16'h1);
      cmd <= {2'h0, 3'($urandom_range(7, 1))};
    end
    pulse(3'h2, 3'h0, 1'b0);
    wait_start(1'b0);
    @(posedge mclk);
    err_clr <= 1'b1;
    @(posedge mclk);
    err_clr <= 1'b0;
    cyc(3);
    chk("gerr irq", 16'({gerr, irq}), 16'h0);
    give_verdict();
  end
endmodule : can_tx_scheduler_bit_timing_test
